/* File: hdl/lprc_pkg.sv */
// Package of constants and types for the low-power mode and reset control.
package lprc_pkg;

  // ---------------------------------------------------------------------------
  // Bus register offsets (byte addresses)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] LPRC_OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] LPRC_OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] LPRC_OFS_TRAP = 8'h08;
  localparam logic [7:0] LPRC_OFS_INTR = 8'h0C;
  localparam logic [7:0] LPRC_OFS_STATUS = 8'h10;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int LPRC_BIT_STOP = 7;
  localparam int LPRC_BIT_WAKE_RELEASE_MODE_SELECT = 6;
  localparam int LPRC_BIT_WUT_HI = 3;
  localparam int LPRC_BIT_WUT_LO = 2;
  localparam int LPRC_BIT_DIV = 1;
  localparam int LPRC_BIT_IDLE = 4;
  localparam int LPRC_BIT_IMF = 0;
  localparam int LPRC_BIT_TRAP_ALLOW = 0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] LPRC_RST_CTRL_ONE = 8'h00;
  localparam logic [7:0] LPRC_RST_CTRL_TWO = 8'h00;
  localparam logic LPRC_RST_JF = 1'b1;
  localparam logic LPRC_RST_TRAP_ALLOW = 1'b1;
  localparam logic [7:0] LPRC_TRAP_KEY = 8'hA5;
  localparam logic [19:0] LPRC_RESET_VECTOR = 20'hFFFFC;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int LPRC_CLK_MHZ = 125;
  localparam int LPRC_WU_CODE00 = 3 * (2 ** 16);
  localparam int LPRC_WU_CODE01 = 2 ** 16;
  localparam int LPRC_WU_CODE10 = 2 ** 14;
  localparam int LPRC_RST_MIN_FC = 12;
  localparam int LPRC_RST_SYNC_CYC = 2;

  typedef enum logic [3:0] {
    LPRC_RUN = 4'h1,
    LPRC_STOP = 4'h2,
    LPRC_WARM = 4'h4,
    LPRC_IDLE = 4'h8
  } lprc_mode_e;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hsel;
    logic hready;
    logic [31:0] hwdata;
  } lprc_ahb_req_s;

  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } lprc_ahb_rsp_s;

endpackage : lprc_pkg

/* File: hdl/lprc_ctrl.sv */
// Low-power mode sequencer and reset combiner with an AHB-Lite slave.
`timescale 1ns/1ns
// -----------------------------------------------------------------------------
// Overview of operation
// - Edge mode: wake pin rising edge leaves sleep.
// - Edge mode enters deep sleep despite high pin.
// - Release starts with only oscillator running.
// - Warm-up keeps internal circuits idle.
// - Two-bit warm-up select, code 11 reserved.
// - Warm-up counts 3x2^16, 2^16, 2^14, doubled.
// - Resume after warm-up, timing divider cleared.
// - Release clears deep-sleep command bit.
// - Bit 7 of control one enters deep sleep.
// - Reset pin low in sleep resets after twelve synchronised low cycles.
// - Light sleep halts CPU and watchdog only.
// - Light sleep preserves state; PC skips two.
// - Bit 4 of control two enters light sleep.
// - Master off: enabled source wakes, no vector.
// - Master on: enabled source wakes into handler.
// - Pending watchdog interrupt blocks light sleep.
// - Four reset sources combine into one reset.
// - Power-on sys_rst clears internal reset causes.
// - Reset sets bank, flags, enables, latches.
// - Reset release fetches vector at FFFFC.
// - Fetch from trap areas causes reset.
// - Trap permitted after reset; software may prohibit.
// -----------------------------------------------------------------------------
module lprc_ctrl
  import lprc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pins
  input wire logic wakePin_n,
  input wire logic resetPin_n,
  // Bus
  input wire lprc_ahb_req_s ahbReq,
  output lprc_ahb_rsp_s ahbRsp,
  // Core side
  input wire logic fetchInTrapArea,
  input wire logic watchdogReset,
  input wire logic systemClockReset,
  input wire logic watchdogIntPending,
  input wire logic [7:0] interruptRequest,
  output logic cpuHalt,
  output logic watchdogHalt,
  output logic periphHalt,
  output logic oscillatorRun,
  output logic timingDividerClear,
  output logic wakeVector,
  output logic chipReset,
  output logic [19:0] resetVector,
  output logic [1:0] registerBankSelector,
  output logic jumpStatusFlag,
  output logic interruptNestingFlag,
  output logic watchdogEnable,
  output logic [7:0] interruptPendingLatch
);

  typedef struct packed {
    logic [1:0] wakeSync;
    logic [1:0] rstSync;
    logic wakePrev;
    logic [7:0] systemControlOne;
    logic [7:0] systemControlTwo;
    logic trapAllow;
    logic masterInterruptEnable;
    logic [7:0] individualInterruptEnable;
    logic [7:0] pendingLatch;
    lprc_mode_e mode;
    logic [19:0] warmCount;
    logic [4:0] lowCount;
    logic internalReset;
    logic vectorPulse;
    logic [7:0] addrPhase;
    logic writePhase;
    logic [31:0] rdata;
  } lprc_state_s;

  lprc_state_s st;
  lprc_state_s next_st;

  // ---------------------------------------------------------------------------
  // Warm-up length
  // ---------------------------------------------------------------------------
  function automatic logic [19:0] warmLength(input logic [1:0] sel,
                                             input logic dbl);
    logic [19:0] base;
    base = 20'h00000;
    case (sel)
      2'b00: base = 20'(LPRC_WU_CODE00);
      2'b01: base = 20'(LPRC_WU_CODE01);
      2'b10: base = 20'(LPRC_WU_CODE10);
      default: base = 20'(LPRC_WU_CODE10);
    endcase
    return dbl ? {base[18:0], 1'b0} : base;
  endfunction : warmLength

  logic extResetValid;
  logic anyReset;
  logic wakeEvent;

  // Reset pin counts as a reset only after twelve synchronised low cycles.
  assign extResetValid = st.lowCount >= 5'(LPRC_RST_MIN_FC);
  assign anyReset = extResetValid | st.internalReset;
  assign wakeEvent = |(st.pendingLatch & st.individualInterruptEnable);

  always_comb begin
    logic addrOk;
    logic [7:0] wd;
    addrOk = 1'b0;
    wd = 8'h00;
    next_st = st;
    // the first stage feeds only the second.
    next_st.wakeSync = {st.wakeSync[0], wakePin_n};
    next_st.rstSync = {st.rstSync[0], resetPin_n};
    next_st.wakePrev = st.wakeSync[1];
    next_st.vectorPulse = 1'b0;
    if (!st.rstSync[1] && st.lowCount < 5'(LPRC_RST_MIN_FC)) begin
      next_st.lowCount = st.lowCount + 5'd1;
    end else if (st.rstSync[1]) begin
      next_st.lowCount = 5'd0;
    end
    // Internal causes; sys_rst clears these and zeroes the state except the synchronisers, wakePrev, trapAllow and mode.
    next_st.internalReset = watchdogReset | systemClockReset
      | (fetchInTrapArea & st.trapAllow);
    next_st.pendingLatch = st.pendingLatch | interruptRequest;

    // Bus slave: zero-wait, always OKAY.
    addrOk = ahbReq.hsel & ahbReq.hready & ahbReq.htrans[1];
    if (st.writePhase) begin
      wd = ahbReq.hwdata[7:0];
      case (st.addrPhase)
        LPRC_OFS_CTRL_ONE: next_st.systemControlOne = wd;
        LPRC_OFS_CTRL_TWO: begin
          next_st.systemControlTwo = wd;
          if (watchdogIntPending) begin
            next_st.systemControlTwo[LPRC_BIT_IDLE] = 1'b0;
          end
        end
        LPRC_OFS_TRAP: begin
          if (wd == LPRC_TRAP_KEY) next_st.trapAllow = 1'b0;
          else if (wd == 8'h00) next_st.trapAllow = 1'b1;
        end
        LPRC_OFS_INTR: begin
          next_st.masterInterruptEnable = ahbReq.hwdata[8 + LPRC_BIT_IMF];
          next_st.individualInterruptEnable = ahbReq.hwdata[23:16];
          // Software clears latches by writing ones; new requests win.
          next_st.pendingLatch = (st.pendingLatch & ~wd) | interruptRequest;
        end
        default: ;
      endcase
    end
    next_st.writePhase = addrOk & ahbReq.hwrite;
    next_st.addrPhase = ahbReq.haddr[7:0];
    if (addrOk && !ahbReq.hwrite) begin
      case (ahbReq.haddr[7:0])
        LPRC_OFS_CTRL_ONE: next_st.rdata = {24'h0, st.systemControlOne};
        LPRC_OFS_CTRL_TWO: next_st.rdata = {24'h0, st.systemControlTwo};
        LPRC_OFS_INTR: next_st.rdata = {8'h0,
          st.individualInterruptEnable, 7'h0, st.masterInterruptEnable,
          st.pendingLatch};
        LPRC_OFS_STATUS: next_st.rdata = {26'h0, st.trapAllow,
          st.internalReset, st.mode};
        default: next_st.rdata = 32'h0;
      endcase
    end

    // Mode sequencer.
    case (st.mode)
      LPRC_RUN: begin
        if (st.systemControlOne[LPRC_BIT_STOP]) begin
          next_st.mode = LPRC_STOP;
        end else if (st.systemControlTwo[LPRC_BIT_IDLE]) begin
          next_st.mode = LPRC_IDLE;
        end
      end
      LPRC_STOP: begin
        if (!st.systemControlOne[LPRC_BIT_WAKE_RELEASE_MODE_SELECT]
            && st.wakeSync[1] && !st.wakePrev) begin
          next_st.mode = LPRC_WARM;
          next_st.warmCount = warmLength(
            st.systemControlOne[LPRC_BIT_WUT_HI:LPRC_BIT_WUT_LO],
            st.systemControlOne[LPRC_BIT_DIV]);
          next_st.systemControlOne[LPRC_BIT_STOP] = 1'b0;
        end else if (st.systemControlOne[LPRC_BIT_WAKE_RELEASE_MODE_SELECT]
                     && st.wakeSync[1]) begin
          next_st.mode = LPRC_WARM;
          next_st.warmCount = warmLength(
            st.systemControlOne[LPRC_BIT_WUT_HI:LPRC_BIT_WUT_LO],
            st.systemControlOne[LPRC_BIT_DIV]);
          next_st.systemControlOne[LPRC_BIT_STOP] = 1'b0;
        end
      end
      LPRC_WARM: begin
        if (st.warmCount <= 20'd1) begin
          next_st.mode = LPRC_RUN;
          next_st.warmCount = 20'd0;
        end else begin
          next_st.warmCount = st.warmCount - 20'd1;
        end
      end
      LPRC_IDLE: begin
        if (wakeEvent) begin
          next_st.mode = LPRC_RUN;
          next_st.systemControlTwo[LPRC_BIT_IDLE] = 1'b0;
          next_st.vectorPulse = st.masterInterruptEnable;
        end
      end
      default: next_st.mode = LPRC_RUN;
    endcase

    // Any reset source wins over every mode.
    if (anyReset) begin
      next_st.mode = LPRC_RUN;
      next_st.systemControlOne = LPRC_RST_CTRL_ONE;
      next_st.systemControlTwo = LPRC_RST_CTRL_TWO;
      next_st.masterInterruptEnable = 1'b0;
      next_st.individualInterruptEnable = 8'h00;
      next_st.pendingLatch = 8'h00;
      next_st.trapAllow = LPRC_RST_TRAP_ALLOW;
      next_st.warmCount = 20'd0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.wakeSync <= 2'b11;
      st.rstSync <= 2'b11;
      st.wakePrev <= 1'b1;
      st.trapAllow <= LPRC_RST_TRAP_ALLOW;
      st.mode <= LPRC_RUN;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign ahbRsp.hrdata = st.rdata;
  assign ahbRsp.hreadyout = 1'b1;
  assign ahbRsp.hresp = 1'b0;
  assign cpuHalt = st.mode != LPRC_RUN;
  assign watchdogHalt = st.mode != LPRC_RUN;
  assign periphHalt = st.mode == LPRC_STOP || st.mode == LPRC_WARM;
  assign oscillatorRun = st.mode != LPRC_STOP;
  assign timingDividerClear = st.mode == LPRC_STOP
    || st.mode == LPRC_WARM || anyReset;
  assign wakeVector = st.vectorPulse;
  assign chipReset = anyReset | sys_rst;
  assign resetVector = LPRC_RESET_VECTOR;
  assign registerBankSelector = 2'b00;
  assign jumpStatusFlag = LPRC_RST_JF;
  assign interruptNestingFlag = 1'b0;
  assign watchdogEnable = 1'b1;
  assign interruptPendingLatch = st.pendingLatch;

endmodule : lprc_ctrl

/* File: tb/lprc_sva.sv */
// Port-level assertions for the low-power mode and reset control.
`timescale 1ns/1ns
module lprc_sva
  import lprc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Watched ports
  input wire logic resetPin_n,
  input wire logic watchdogReset,
  input wire logic systemClockReset,
  input wire logic cpuHalt,
  input wire logic watchdogHalt,
  input wire logic periphHalt,
  input wire logic oscillatorRun,
  input wire logic timingDividerClear,
  input wire logic chipReset,
  input wire logic [19:0] resetVector,
  input wire logic [1:0] registerBankSelector,
  input wire logic jumpStatusFlag,
  input wire logic interruptNestingFlag,
  input wire logic watchdogEnable
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_VECTOR:
    assert property (resetVector == LPRC_RESET_VECTOR)
    else $error("reset vector wrong");
  AST_INIT:
    assert property (chipReset |-> registerBankSelector == 2'h0 &&
      jumpStatusFlag && !interruptNestingFlag && watchdogEnable)
    else $error("reset values wrong");
  AST_STOP_QUIET:
    assert property (!oscillatorRun |-> periphHalt && cpuHalt &&
      timingDividerClear)
    else $error("circuits run while oscillator stopped");
  AST_WARM_IDLE:
    assert property ($rose(oscillatorRun) && !chipReset |->
      periphHalt && watchdogHalt)
    else $error("warm-up not idle");
  AST_LIGHT:
    assert property (cpuHalt && !periphHalt |-> watchdogHalt &&
      oscillatorRun)
    else $error("light sleep halts wrong units");
  AST_INTERNAL:
    assert property ($rose(watchdogReset) || $rose(systemClockReset)
      |-> ##[0:3] chipReset)
    else $error("internal reset not combined");
  AST_PIN_HOLD:
    assert property (!resetPin_n [*8] ##1 !resetPin_n [*8] |->
      ##[0:3] chipReset)
    else $error("held reset pin ignored");
  AST_PIN_FREE:
    assert property ($rose(resetPin_n) |-> ##[1:4] !chipReset)
    else $error("reset not left after pin release");
endmodule : lprc_sva

/* File: tb/lprc_pin_model.sv */
// Wake pin source and reset pin circuitry outside the device.
`timescale 1ns/1ns
module lprc_pin_model (
  // Clock
  input wire logic clk,
  // Bench commands
  input wire logic wakeGo,
  input wire logic rstGo,
  input wire logic [7:0] rstLen,
  // Pins
  output logic wakePin_n,
  output logic resetPin_n
);
  int wakeCnt = 0;
  int rstCnt = 0;
  always @(posedge clk) begin
    if (wakeGo) wakeCnt <= 4;
    else if (wakeCnt > 0) wakeCnt <= wakeCnt - 1;
    // Shorter pulses are stretched, since the device may ignore them.
    if (rstGo) rstCnt <= (rstLen < 8'd12) ? 12 : int'(rstLen);
    else if (rstCnt > 0) rstCnt <= rstCnt - 1;
  end
  assign wakePin_n = (wakeCnt == 0);
  assign resetPin_n = (rstCnt == 0);
endmodule : lprc_pin_model

/* File: tb/testbench.sv */
// Self-checking bench for the low-power mode and reset control.
`timescale 1ns/1ns
module testbench;
  import lprc_pkg::*;
  logic clk, sys_rst, wakeGo, rstGo, fetch, wdRst, scRst, wdPend, jsf;
  logic wakePin_n, resetPin_n, cpuHalt, watchdogHalt, periphHalt, oscRun;
  logic divClr, wakeVector, chipReset, interrupt_nesting_flag, wdEn;
  logic [19:0] resetVector;
  logic [1:0] register_bank_selector;
  logic [7:0] intReq, latch;
  logic [31:0] q;
  lprc_ahb_req_s req;
  lprc_ahb_rsp_s rsp;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int n, wu;
  lprc_pin_model pins (.clk(clk), .wakeGo(wakeGo), .rstGo(rstGo),
    .rstLen(8'd40), .wakePin_n(wakePin_n), .resetPin_n(resetPin_n));
  lprc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .wakePin_n(wakePin_n),
    .resetPin_n(resetPin_n), .ahbReq(req), .ahbRsp(rsp),
    .fetchInTrapArea(fetch), .watchdogReset(wdRst),
    .systemClockReset(scRst), .watchdogIntPending(wdPend),
    .interruptRequest(intReq), .cpuHalt(cpuHalt),
    .watchdogHalt(watchdogHalt), .periphHalt(periphHalt),
    .oscillatorRun(oscRun), .timingDividerClear(divClr),
    .wakeVector(wakeVector), .chipReset(chipReset),
    .resetVector(resetVector), .registerBankSelector(register_bank_selector),
    .jumpStatusFlag(jsf), .interruptNestingFlag(interrupt_nesting_flag),
    .watchdogEnable(wdEn), .interruptPendingLatch(latch));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // The longest warm-up tested is about 33k cycles; this leaves ample room.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      $display("mismatch at %0t: run timed out", $time);
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    req.haddr <= {24'h0, a};
    req.htrans <= 2'h2;
    req.hwrite <= w;
    req.hsel <= 1'b1;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    req.htrans <= 2'h0;
    req.hwdata <= d;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    q = rsp.hrdata;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(q, exp);
  endtask : rd
  initial begin
    sys_rst = 1'b1;
    {wakeGo, rstGo, fetch, wdRst, scRst, wdPend} = 6'h00;
    intReq = 8'h00;
    req = '0;
    req.hsize = 3'h2;
    req.hready = 1'b1;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(LPRC_OFS_STATUS, 32'h21);
    rd(8'h20, 32'h0);
    rd(LPRC_OFS_INTR, 32'h0);
    for (int dv = 0; dv < 2; dv++) begin
      wu = LPRC_WU_CODE10 << dv;
      bus(LPRC_OFS_CTRL_ONE, 1'b1, 32'h88 | (dv << 1));
      repeat (20) @(posedge clk);
      rd(LPRC_OFS_STATUS, 32'h22);
      chk(oscRun, 1'b0);
      wakeGo <= 1'b1;
      @(posedge clk);
      wakeGo <= 1'b0;
      n = 0;
      while (cpuHalt !== 1'b0 && n < 40000) begin
        @(posedge clk);
        n++;
      end
      chk(n >= wu && n <= wu + 16, 1'b1);
      chk(divClr, 1'b0);
      rd(LPRC_OFS_CTRL_ONE, 32'h08 | (dv << 1));
    end
    // Level release with the pin already high leaves the stop after one cycle and warms up.
    bus(LPRC_OFS_CTRL_ONE, 1'b1, 32'hC8);
    repeat (6) @(posedge clk);
    chk({periphHalt, oscRun, divClr}, 3'b111);
    repeat (LPRC_WU_CODE10 + 8) @(posedge clk);
    chk(cpuHalt, 1'b0);
    rd(LPRC_OFS_CTRL_ONE, 32'h48);
    bus(LPRC_OFS_CTRL_ONE, 1'b1, 32'h88);
    repeat (20) @(posedge clk);
    rstGo <= 1'b1;
    @(posedge clk);
    rstGo <= 1'b0;
    repeat (20) @(posedge clk);
    chk(chipReset, 1'b1);
    repeat (30) @(posedge clk);
    chk(chipReset, 1'b0);
    rd(LPRC_OFS_STATUS, 32'h21);
    rd(LPRC_OFS_CTRL_ONE, 32'h0);
    for (int m = 0; m < 2; m++) begin
      bus(LPRC_OFS_INTR, 1'b1, 32'h10000 | (m << 8));
      bus(LPRC_OFS_CTRL_TWO, 1'b1, 32'h10);
      repeat (4) @(posedge clk);
      chk({cpuHalt, watchdogHalt, periphHalt}, 3'b110);
      intReq <= 8'h01;
      @(posedge clk);
      intReq <= 8'h00;
      n = 0;
      repeat (12) begin
        @(posedge clk);
        if (wakeVector === 1'b1) n++;
      end
      chk(cpuHalt, 1'b0);
      chk(n, m);
      if (m == 0) chk(latch, 8'h01);
      bus(LPRC_OFS_INTR, 1'b1, 32'h1);
    end
    wdPend <= 1'b1;
    bus(LPRC_OFS_CTRL_TWO, 1'b1, 32'h10);
    repeat (4) @(posedge clk);
    chk(cpuHalt, 1'b0);
    wdPend <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      repeat (16) @(posedge clk);
      if (i == 3) bus(LPRC_OFS_TRAP, 1'b1, 32'hA5);
      {fetch, scRst, wdRst} <= (i == 3) ? 3'b100 : 3'(1 << i);
      @(posedge clk);
      {fetch, scRst, wdRst} <= 3'b000;
      n = 0;
      repeat (8) begin
        @(posedge clk);
        if (chipReset === 1'b1) n++;
      end
      chk(n > 0, i < 3);
    end
    rd(LPRC_OFS_STATUS, 32'h01);
    finish_test();
  end
endmodule : testbench
bind lprc_ctrl lprc_sva sva (.clk(clk), .sys_rst(sys_rst),
  .resetPin_n(resetPin_n), .watchdogReset(watchdogReset),
  .systemClockReset(systemClockReset), .cpuHalt(cpuHalt),
  .watchdogHalt(watchdogHalt), .periphHalt(periphHalt),
  .oscillatorRun(oscillatorRun), .timingDividerClear(timingDividerClear),
  .chipReset(chipReset), .resetVector(resetVector),
  .registerBankSelector(registerBankSelector),
  .jumpStatusFlag(jumpStatusFlag),
  .interruptNestingFlag(interruptNestingFlag),
  .watchdogEnable(watchdogEnable));
